/* File: hw/cshbp_mem.sv */
`timescale 1ns/100ps
module cshbp_mem
(
    input wire logic core_clk_i,
    input wire logic [cshbp_pkg::MEM_IDX_W-1:0] addr_i,
    input wire logic [1:0] wr_be_i,
    input wire logic [cshbp_pkg::DATA_W-1:0] wdata_i,
    output logic [cshbp_pkg::DATA_W-1:0] rdata_o
);
    import cshbp_pkg::*;

    logic [DATA_W-1:0] mem_q [MEM_WORDS];

    always_ff @(posedge core_clk_i)
    begin
        if (wr_be_i[0])
        begin
            mem_q[addr_i][7:0] <= wdata_i[7:0];
        end
        if (wr_be_i[1])
        begin
            mem_q[addr_i][15:8] <= wdata_i[15:8];
        end
        rdata_o <= mem_q[addr_i];
    end
endmodule

/* File: hw/cshbp_pkg.sv */
// Operation
// - latch straps once after power-up reset
// - bus-style strap high selects style two
// - byte-order strap high selects big-endian
// - host-bus-type straps all ones: generic family
// - style two: byte-high enable, write, read
// - style one: separate byte read/write strobes
// - synchronise asynchronous host strobes internally
// - display memory at offsets up to limit
// - control registers in top 32 bytes
package cshbp_pkg;
    localparam int unsigned ADDR_W = 16;
    localparam int unsigned DATA_W = 16;
    localparam logic [2:0] HOST_TYPE_GENERIC = 3'h7;
    localparam int unsigned STRAP_BYTE_ORDER_BIT = 3;
    localparam logic [15:0] MEM_LAST = 16'h9fff;
    localparam logic [15:0] REG_FIRST = 16'hffe0;
    localparam int unsigned REG_IDX_W = 5;
    localparam int unsigned MEM_WORDS = 20480;
    localparam int unsigned MEM_IDX_W = 15;

    typedef struct packed {
        logic generic_ok;
        logic style_two;
        logic big_endian;
    } cshbp_cfg_t;

    typedef struct packed {
        logic wr_hi;
        logic wr_lo;
        logic rd_hi;
        logic rd_lo;
    } cshbp_lanes_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WRITE = 4'b0010,
        ST_READ = 4'b0100,
        ST_WAIT = 4'b1000
    } cshbp_state_t;
endpackage

/* File: hw/cshbp_port.sv */
`timescale 1ns/100ps
module cshbp_port
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] config_straps_i,
    input wire logic bus_style_strap_i,
    input wire logic [cshbp_pkg::ADDR_W-1:0] host_addr_i,
    input wire logic [cshbp_pkg::DATA_W-1:0] host_data_i,
    input wire logic high_byte_write_strobe_n_i,
    input wire logic low_byte_write_strobe_n_i,
    input wire logic rd_wr_dual_n_i,
    input wire logic low_byte_read_strobe_n_i,
    output logic [cshbp_pkg::DATA_W-1:0] host_data_o,
    output logic host_data_oe_o,
    output logic [cshbp_pkg::REG_IDX_W-1:0] reg_idx_o,
    output logic [cshbp_pkg::DATA_W-1:0] reg_wdata_o,
    output logic [1:0] reg_wr_be_o,
    output logic reg_rd_o,
    input wire logic [cshbp_pkg::DATA_W-1:0] reg_rdata_i,
    output logic style_two_o,
    output logic big_endian_o,
    output logic generic_ok_o
);
    import cshbp_pkg::*;

    cshbp_cfg_t cfg_q;
    logic cfg_done_q;
    logic [4:0] strap_s1_q;
    logic [4:0] strap_s2_q;
    logic style_s1_q;
    logic style_s2_q;
    cshbp_state_t state_q;
    logic [3:0] strb_s1_q;
    logic [3:0] strb_s2_q;
    logic [ADDR_W-1:0] addr_s1_q;
    logic [ADDR_W-1:0] addr_s2_q;
    logic [DATA_W-1:0] data_s1_q;
    logic [DATA_W-1:0] data_s2_q;
    cshbp_lanes_t lanes;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata_sw;
    logic in_mem;
    logic in_reg;
    logic any_wr;
    logic any_rd;
    logic [1:0] be;
    logic [1:0] mem_be;
    logic [DATA_W-1:0] mem_rdata;
    logic [DATA_W-1:0] rsel;
    logic rd_mem_q;
    logic [1:0] rd_be_q;

    // strap pins are free running through two flops, settled during reset
    always_ff @(posedge core_clk_i)
    begin
        strap_s1_q <= config_straps_i;
        strap_s2_q <= strap_s1_q;
        style_s1_q <= bus_style_strap_i;
        style_s2_q <= style_s1_q;
    end

    // straps sampled once after reset release, then frozen
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            cfg_q <= '0;
            cfg_done_q <= 1'b0;
        end
        else if (!cfg_done_q)
        begin
            cfg_q.generic_ok <= strap_s2_q[2:0] == HOST_TYPE_GENERIC;
            cfg_q.style_two <= style_s2_q;
            cfg_q.big_endian <= strap_s2_q[STRAP_BYTE_ORDER_BIT];
            cfg_done_q <= 1'b1;
        end
    end

    // strobes and bus held stable while strobes active; double flopped
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            strb_s1_q <= 4'hf;
            strb_s2_q <= 4'hf;
            addr_s1_q <= '0;
            addr_s2_q <= '0;
            data_s1_q <= '0;
            data_s2_q <= '0;
        end
        else
        begin
            strb_s1_q <= {high_byte_write_strobe_n_i, low_byte_write_strobe_n_i,
                rd_wr_dual_n_i, low_byte_read_strobe_n_i};
            strb_s2_q <= strb_s1_q;
            addr_s1_q <= host_addr_i;
            addr_s2_q <= addr_s1_q;
            data_s1_q <= host_data_i;
            data_s2_q <= data_s1_q;
        end
    end

    always_comb
    begin
        addr = addr_s2_q;
        if (cfg_q.style_two)
        begin
            // high write pin is byte-high enable, low write pin the strobe
            lanes.wr_lo = !strb_s2_q[2] && addr[0] == 1'b0;
            lanes.wr_hi = !strb_s2_q[2] && !strb_s2_q[3];
            lanes.rd_lo = !strb_s2_q[0] && addr[0] == 1'b0;
            lanes.rd_hi = !strb_s2_q[0] && !strb_s2_q[3];
        end
        else
        begin
            lanes.wr_hi = !strb_s2_q[3];
            lanes.wr_lo = !strb_s2_q[2];
            lanes.rd_hi = !strb_s2_q[1];
            lanes.rd_lo = !strb_s2_q[0];
        end
        if (!cfg_q.generic_ok || !cfg_done_q)
        begin
            lanes = '0;
        end
        any_wr = lanes.wr_hi || lanes.wr_lo;
        any_rd = lanes.rd_hi || lanes.rd_lo;
        be = {lanes.wr_hi, lanes.wr_lo};
        // lane swap keeps byte addresses consistent in big-endian mode
        wdata_sw = cfg_q.big_endian ? {data_s2_q[7:0], data_s2_q[15:8]}
            : data_s2_q;
        if (cfg_q.big_endian)
        begin
            be = {be[0], be[1]};
        end
        in_mem = addr <= MEM_LAST;
        in_reg = addr >= REG_FIRST;
        mem_be = (state_q == ST_IDLE && any_wr && in_mem) ? be : 2'b00;
    end

    cshbp_mem u_mem
    (
        .core_clk_i(core_clk_i),
        .addr_i(addr[MEM_IDX_W:1]),
        .wr_be_i(mem_be),
        .wdata_i(wdata_sw),
        .rdata_o(mem_rdata)
    );

    // one access per strobe assertion; wait for release before next
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            state_q <= ST_IDLE;
            reg_wr_be_o <= 2'b00;
            reg_rd_o <= 1'b0;
            reg_idx_o <= '0;
            reg_wdata_o <= '0;
            rd_mem_q <= 1'b0;
            rd_be_q <= 2'b00;
        end
        else
        begin
            reg_wr_be_o <= 2'b00;
            reg_rd_o <= 1'b0;
            unique case (state_q)
                ST_IDLE:
                begin
                    reg_idx_o <= addr[REG_IDX_W-1:0];
                    reg_wdata_o <= wdata_sw;
                    if (any_wr)
                    begin
                        reg_wr_be_o <= in_reg ? be : 2'b00;
                        state_q <= ST_WAIT;
                    end
                    else if (any_rd)
                    begin
                        reg_rd_o <= in_reg;
                        rd_mem_q <= in_mem;
                        rd_be_q <= {lanes.rd_hi, lanes.rd_lo};
                        state_q <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    state_q <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (!any_wr && !any_rd)
                    begin
                        state_q <= ST_IDLE;
                    end
                end
                ST_WRITE:
                begin
                    state_q <= ST_WAIT;
                end
            endcase
        end
    end

    always_comb
    begin
        rsel = rd_mem_q ? mem_rdata : reg_rdata_i;
        if (cfg_q.big_endian)
        begin
            rsel = {rsel[7:0], rsel[15:8]};
        end
    end

    // data driven from the cycle after ST_READ until strobes release
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            host_data_o <= '0;
            host_data_oe_o <= 1'b0;
        end
        else
        begin
            if (state_q == ST_READ)
            begin
                host_data_o <= rsel;
                host_data_oe_o <= rd_be_q != 2'b00;
            end
            else if (!any_rd)
            begin
                host_data_oe_o <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            style_two_o <= 1'b0;
            big_endian_o <= 1'b0;
            generic_ok_o <= 1'b0;
        end
        else
        begin
            style_two_o <= cfg_q.style_two;
            big_endian_o <= cfg_q.big_endian;
            generic_ok_o <= cfg_q.generic_ok;
        end
    end
endmodule

/* File: tb/cshbp_host_model.sv */
`timescale 1ns/100ps
module cshbp_host_model
(
    input wire logic core_clk_i,
    input wire logic style_two_i,
    input wire logic [15:0] rdata_i,
    input wire logic rdata_oe_i,
    output logic [15:0] addr_o,
    output logic [15:0] data_o,
    output cshbp_pkg::cshbp_lanes_t strobes_n_o,
    output logic card_side_en_o
);
    import cshbp_pkg::*;
    logic [7:0] copy_q = 8'h00;
    initial {addr_o, data_o, strobes_n_o} = 36'h0_0000_000f;
    initial card_side_en_o = 1'b1;
    task automatic acc(input logic wr, input logic [15:0] a, d,
        input logic [1:0] be, output logic [15:0] q);
        logic [31:0] bus_a;
        @(posedge core_clk_i);
        #1;
        // each access lands in another 64K copy of the window
        bus_a = 32'h0900_0000 + {8'h00, copy_q, a};
        copy_q = copy_q + 8'h01;
        card_side_en_o = 1'b0;
        // only the low half of the latched address reaches the port
        addr_o = {bus_a[15:1], style_two_i & !be[0]};
        data_o = d;
        strobes_n_o.wr_hi = !(be[1] & (wr | style_two_i));
        strobes_n_o.wr_lo = !(wr & (style_two_i | be[0]));
        strobes_n_o.rd_hi = !(!wr & !style_two_i & be[1]);
        strobes_n_o.rd_lo = !(!wr & (style_two_i | be[0]));
        repeat (7) @(posedge core_clk_i);
        q = rdata_oe_i ? rdata_i : 16'hxxxx;
        #1;
        strobes_n_o = 4'hf;
        card_side_en_o = 1'b1;
        // released bus must not keep showing the last value
        data_o = ~d;
        addr_o = ~addr_o;
        repeat (4) @(posedge core_clk_i);
    endtask
endmodule

/* File: tb/cshbp_port_asserts.sv */
`timescale 1ns/100ps
module cshbp_port_chk
(
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [4:0] config_straps_i,
    input wire logic bus_style_strap_i,
    input wire logic [15:0] host_addr_i,
    input wire logic high_byte_write_strobe_n_i,
    input wire logic low_byte_write_strobe_n_i,
    input wire logic rd_wr_dual_n_i,
    input wire logic low_byte_read_strobe_n_i,
    input wire logic host_data_oe_o,
    input wire logic [4:0] reg_idx_o,
    input wire logic [1:0] reg_wr_be_o,
    input wire logic reg_rd_o,
    input wire logic style_two_o,
    input wire logic big_endian_o,
    input wire logic generic_ok_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (sys_rst_i);
    a_cfg_held: assert property ($past(generic_ok_o) |->
        $stable({style_two_o, big_endian_o})) else $error("cfg moved");
    a_style_latch: assert property ($rose(generic_ok_o) |->
        style_two_o == bus_style_strap_i) else $error("style");
    a_order_latch: assert property ($rose(generic_ok_o) |->
        big_endian_o == config_straps_i[3]) else $error("order");
    a_type_gate: assert property (!generic_ok_o |-> !reg_rd_o &&
        !host_data_oe_o && reg_wr_be_o == 2'h0) else $error("gate");
    a_reg_read: assert property (reg_rd_o |-> &host_addr_i[15:5] &&
        reg_idx_o == host_addr_i[4:0] ##1 !reg_rd_o) else $error("reg rd");
    a_reg_write: assert property (|reg_wr_be_o |->
        (style_two_o ? !low_byte_write_strobe_n_i :
        !(low_byte_write_strobe_n_i && high_byte_write_strobe_n_i)) &&
        &host_addr_i[15:5] ##1
        reg_wr_be_o == 2'h0) else $error("reg wr");
    a_read_drive: assert property ($rose(host_data_oe_o) |->
        !low_byte_read_strobe_n_i) else $error("oe no rd");
    a_oe_release: assert property
        ((low_byte_read_strobe_n_i && rd_wr_dual_n_i)[*5] |->
        !host_data_oe_o) else $error("oe held");
    c_reg_rd: cover property (reg_rd_o);
    c_reg_wr: cover property (reg_wr_be_o == 2'h3);
    c_mem_rd: cover property ($rose(host_data_oe_o));
endmodule
bind cshbp_port cshbp_port_chk u_chk (.*);

/* File: tb/tb_card_slot_host_bus_port.sv */
`timescale 1ns/100ps
module tb_card_slot_host_bus_port;
    import cshbp_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [4:0] config_straps_i = 5'h0f;
    logic bus_style_strap_i = 1'b0;
    logic [15:0] host_addr_i, host_data_i, host_data_o, reg_wdata_o;
    logic [15:0] reg_rdata_i;
    logic high_byte_write_strobe_n_i, low_byte_write_strobe_n_i, reg_rd_o;
    logic rd_wr_dual_n_i, low_byte_read_strobe_n_i, host_data_oe_o;
    logic [4:0] reg_idx_o;
    logic [1:0] reg_wr_be_o;
    logic style_two_o, big_endian_o, generic_ok_o;
    logic sty = 1'b0;
    logic bg = 1'b0;
    int reg_writes = 0;
    int w0 = 0;
    logic card_en;
    logic [15:0] q, wa, wd;
    logic [15:0] lf = 16'h003d;
    logic [15:0] regs [32] = '{default: 16'h0000};
    cshbp_lanes_t sb;
    int fail_count = 0;
    int comparisons = 0;
    int mref [int];
    cshbp_port uut (.*);
    cshbp_host_model host (.core_clk_i, .style_two_i(sty),
        .rdata_i(host_data_o), .rdata_oe_i(host_data_oe_o),
        .addr_o(host_addr_i), .data_o(host_data_i), .strobes_n_o(sb),
        .card_side_en_o(card_en));
    // register file answers combinationally, in the same cycle the index is set
    assign reg_rdata_i = regs[reg_idx_o];
    assign {high_byte_write_strobe_n_i, low_byte_write_strobe_n_i} = sb[3:2];
    assign {rd_wr_dual_n_i, low_byte_read_strobe_n_i} = sb[1:0];
    always #5 core_clk_i = ~core_clk_i;
    always @(posedge core_clk_i)
    begin
        if (sb != 4'hf)
            chk(16'(card_en), 16'h0000);
        if (|reg_wr_be_o)
        begin
            chk(reg_wdata_o, bg ? {wd[7:0], wd[15:8]} : wd);
            chk(16'(reg_wr_be_o), 16'h0003);
            reg_writes <= reg_writes + 1;
            regs[reg_idx_o] <= reg_wdata_o;
        end
    end
    task automatic chk(input logic [15:0] s, x);
        comparisons++;
        if (s !== x)
        begin
            fail_count++;
            $display("CHECK FAILED %0t %h %h", $time, s, x);
        end
    endtask
    function automatic logic [15:0] rnd();
        lf = {lf[14:0], ^(lf & 16'hb400)};
        return lf;
    endfunction
    task automatic wr(input logic [15:0] a, d, input logic [1:0] m);
        logic [15:0] k;
        k = {{8{m[1]}}, {8{m[0]}}};
        host.acc(1'b1, a, d, m, q);
        mref[a[15:1]] = (mref[a[15:1]] & ~k) | (d & k);
    endtask
    task automatic boot(input logic [4:0] s, input logic b);
        @(posedge core_clk_i);
        #1;
        {sys_rst_i, config_straps_i, bus_style_strap_i} = {1'b1, s, b};
        {sty, bg} = {b, s[3]};
        repeat (4) @(posedge core_clk_i);
        #1;
        sys_rst_i = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        chk(16'({style_two_o, big_endian_o, generic_ok_o}),
            16'({b, s[3], &s[2:0]}));
        {config_straps_i, bus_style_strap_i} = ~{s, b};
    endtask
    task automatic complete_run();
        $display("comparisons %0d fail_count %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        for (int c = 0; c < 4; c++)
        begin
            boot({1'b0, c[1], 3'h7}, c[0]);
            for (int i = 0; i < 3; i++)
            begin
                wa = i ? (rnd() % 16'ha000) & 16'hfffe : 16'h9ffe;
                wr(wa, rnd(), 2'h3);
                wr(wa, rnd(), 2'h1 << i[0]);
                host.acc(1'b0, wa, 16'h0000, 2'h3, q);
                chk(q, 16'(mref[wa[15:1]]));
            end
            wd = rnd();
            wa = 16'hffe0 | (wd & 16'h001e);
            w0 = reg_writes;
            host.acc(1'b1, wa, wd, 2'h3, q);
            host.acc(1'b0, wa, 16'h0000, 2'h3, q);
            chk(q, wd);
            chk(16'({reg_writes != w0, style_two_o, big_endian_o,
                generic_ok_o}),
                16'({1'b1, sty, bg, 1'b1}));
        end
        boot(5'h06, 1'b0);
        w0 = reg_writes;
        host.acc(1'b1, 16'hffe0, 16'h1234, 2'h3, q);
        host.acc(1'b0, 16'hffe0, 16'h0000, 2'h3, q);
        chk(q, 16'hxxxx);
        chk(16'(reg_writes - w0), 16'h0000);
        complete_run();
    end
endmodule
